// ---- timer_pkg.sv ----
/*
  timer_pkg: register map, field layout, reset values and shared types for the
  shared counter core of a multi-channel pulse timer.
  assumes: Avalon-MM word slave, 32-bit data, one bus clock at 100 MHz.
*/
// Notes on behaviour
// - one 16-bit counter: free-run, modulo up count, or up/down in center mode
// - modulo limit 0x0000 or 0xffff makes the counter free-running
// - reading the counter never disturbs counting
// - any write to either counter byte clears the counter
// - clock source field bits 4:3 disables or picks one of three sources
// - external pin and fixed system clock are synchronised to bus clock
// - prescale field bits 2:0 divides by 1..128 after synchronisation
// - pin owned by timer ignores port data and direction settings
// - after reset timer disabled, pins general inputs, pullups off
// - up mode: flag bit 7 sets when counter wraps to 0 past modulo
// - center mode: flag sets when counter steps down from modulo
// - clear flag by reading status while set, then writing 0; 1 ignored
// - overflow during clear sequence disarms it so the flag stays set
// - irq enable bit 6 with flag set raises interrupt request
// - center select bit 5 gives up/down count and center PWM on channels
// - reset clears flag, irq enable and center select
// - source codes: 0 off, 1 bus, 2 fixed system, 3 external pin
// - reading either counter byte latches both until the other is read
// - writing a modulo byte inhibits the flag until the other is written
// - reset loads modulo limit with 0x0000
package timer_pkg;
  localparam logic [3:0] addr_status_control = 4'h0;
  localparam logic [3:0] addr_count_high     = 4'h1;
  localparam logic [3:0] addr_count_low      = 4'h2;
  localparam logic [3:0] addr_mod_high       = 4'h3;
  localparam logic [3:0] addr_mod_low        = 4'h4;
  localparam logic [3:0] addr_pin_control    = 4'h5;

  localparam int flag_bit      = 7;
  localparam int irq_en_bit    = 6;
  localparam int center_bit    = 5;
  localparam int src_msb       = 4;
  localparam int src_lsb       = 3;
  localparam int ps_msb        = 2;

  localparam logic [7:0]  status_reset = 8'h00;
  localparam logic [15:0] mod_reset    = 16'h0000;
  localparam logic [15:0] count_reset  = 16'h0000;
  localparam logic [15:0] count_max    = 16'hffff;
  localparam logic [3:0]  pin_reset    = 4'h0;

  typedef enum logic [1:0] {
    src_off   = 2'b00,
    src_bus   = 2'b01,
    src_fixed = 2'b10,
    src_pin   = 2'b11
  } clock_source_e;

  // settings that channels read from the core
  typedef struct packed {
    logic [15:0] counter_value;
    logic        center_mode_select;
    logic        counting_down;
  } core_view_s;
endpackage

// ---- timer_prescaler.sv ----
/*
  timer_prescaler: picks the count source, synchronises slow sources and
  divides the result into one-cycle count ticks.
  assumes: fixed_system_clock and ext_timer_clock_pin are asynchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // settings
  input  wire logic [1:0] clock_source_select,
  input  wire logic [2:0] prescale_select,
  input  wire logic       restart,
  // raw sources
  input  wire logic       fixed_system_clock,
  input  wire logic       ext_timer_clock_pin,
  // output
  output logic            tick
);
  logic [1:0] fix_sync_r;
  logic [1:0] pin_sync_r;
  logic       fix_last_r;
  logic       pin_last_r;
  logic [6:0] div_r;
  logic       src_pulse;
  logic [6:0] div_mask;

  // two flops each, then a separate edge flop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fix_sync_r <= 2'h0;
      pin_sync_r <= 2'h0;
      fix_last_r <= 1'b0;
      pin_last_r <= 1'b0;
    end else begin
      fix_sync_r <= {fix_sync_r[0], fixed_system_clock};
      pin_sync_r <= {pin_sync_r[0], ext_timer_clock_pin};
      fix_last_r <= fix_sync_r[1];
      pin_last_r <= pin_sync_r[1];
    end
  end

  always_comb begin
    case (timer_pkg::clock_source_e'(clock_source_select))
      timer_pkg::src_bus:   src_pulse = 1'b1;
      timer_pkg::src_fixed: src_pulse = fix_sync_r[1] & ~fix_last_r;
      timer_pkg::src_pin:   src_pulse = pin_sync_r[1] & ~pin_last_r;
      default:              src_pulse = 1'b0;
    endcase
  end

  assign div_mask = 7'((8'h01 << prescale_select) - 8'h01);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_r <= 7'h00;
    end else if (restart) begin
      div_r <= 7'h00;
    end else if (src_pulse) begin
      div_r <= (div_r & div_mask) == div_mask ? 7'h00 : div_r + 7'h01;
    end
  end

  assign tick = src_pulse && ((div_r & div_mask) == div_mask);
endmodule
`default_nettype wire

// ---- timer_counter_core.sv ----
/*
  timer_counter_core: 16-bit counter, modulo limit, overflow flag and
  status/control register behind an Avalon-MM slave.
  assumes: one 100 MHz bus clock; byte registers in bits 7:0 of word slots.
*/
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module timer_counter_core (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // avalon-mm slave
  input  wire logic [3:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [3:0]       byteenable,
  input  wire logic [31:0]      writedata,
  output logic [31:0]           readdata,
  output logic                  waitrequest,
  // clock sources
  input  wire logic             fixed_system_clock,
  input  wire logic             ext_timer_clock_pin,
  // channel and pin side
  input  wire logic [3:0]       channel_needs_pin,
  output timer_pkg::core_view_s core_view,
  output logic [3:0]            pin_owned_by_timer,
  output logic [3:0]            pullup_enable,
  // interrupt request
  output logic                  overflow_irq
);
  logic [7:0]  sc_r;
  logic [15:0] count_r;
  logic        down_r;
  logic [15:0] mod_r;
  logic [7:0]  mod_hold_r;
  logic        mod_half_r;
  logic [15:0] latch_r;
  logic        latch_high_r;
  logic        latch_low_r;
  logic        armed_r;
  logic [3:0]  pullup_r;
  logic        ack_r;
  logic [31:0] readdata_r;
  logic        tick;
  logic        rd_go;
  logic        wr_go;
  logic        lane0;
  logic        overflow;
  logic        free_run;
  logic        wr_sc;
  logic        wr_cnt;
  logic [15:0] count_nxt;
  logic        down_nxt;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  // every access answers one cycle after it starts
  assign rd_go       = read & ~ack_r;
  assign wr_go       = write & ~ack_r;
  assign waitrequest = (read | write) & ~ack_r;
  assign lane0       = byteenable[0];
  assign wr_sc       = wr_go & lane0 & hit(address, timer_pkg::addr_status_control);
  assign wr_cnt      = wr_go & lane0 & (hit(address, timer_pkg::addr_count_high) |
                                        hit(address, timer_pkg::addr_count_low));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (rd_go | wr_go);
    end
  end

  timer_prescaler prescaler (
    .clock               (clock),
    .reset               (reset),
    .clock_source_select (sc_r[timer_pkg::src_msb:timer_pkg::src_lsb]),
    .prescale_select     (sc_r[timer_pkg::ps_msb:0]),
    .restart             (wr_cnt),
    .fixed_system_clock  (fixed_system_clock),
    .ext_timer_clock_pin (ext_timer_clock_pin),
    .tick                (tick)
  );

  assign free_run = (mod_r == timer_pkg::mod_reset) || (mod_r == timer_pkg::count_max);

  // next count and overflow event
  always_comb begin
    count_nxt = count_r;
    down_nxt  = down_r;
    overflow  = 1'b0;
    if (tick) begin
      if (sc_r[timer_pkg::center_bit]) begin
        if (down_r) begin
          if (count_r <= 16'h0001) begin
            count_nxt = count_r == 16'h0000 ? 16'h0001 : 16'h0000;
            down_nxt  = count_r == 16'h0000 ? 1'b0 : 1'b1;
            if (count_r == 16'h0000) begin
              count_nxt = 16'h0001;
            end
            if (count_r == 16'h0001) begin
              down_nxt = 1'b0;
            end
          end else begin
            count_nxt = count_r - 16'h0001;
          end
        end else if (!free_run && count_r >= mod_r) begin
          count_nxt = count_r - 16'h0001;
          down_nxt  = 1'b1;
          overflow  = 1'b1;
        end else begin
          count_nxt = count_r + 16'h0001;
          overflow  = count_r == timer_pkg::count_max;
        end
      end else begin
        down_nxt = 1'b0;
        if (!free_run && count_r >= mod_r) begin
          count_nxt = timer_pkg::count_reset;
          overflow  = 1'b1;
        end else begin
          count_nxt = count_r + 16'h0001;
          overflow  = count_r == timer_pkg::count_max;
        end
      end
    end
  end

  // counter; reads leave it alone
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_r <= timer_pkg::count_reset;
      down_r  <= 1'b0;
    end else if (wr_cnt) begin
      count_r <= timer_pkg::count_reset;
      down_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      down_r  <= down_nxt;
    end
  end

  // modulo limit, written a byte at a time
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mod_r      <= timer_pkg::mod_reset;
      mod_hold_r <= 8'h00;
      mod_half_r <= 1'b0;
    end else if (wr_go && lane0 && hit(address, timer_pkg::addr_mod_high)) begin
      mod_hold_r <= writedata[7:0];
      if (mod_half_r) begin
        mod_r      <= {writedata[7:0], mod_hold_r};
        mod_half_r <= 1'b0;
      end else begin
        mod_half_r <= 1'b1;
      end
    end else if (wr_go && lane0 && hit(address, timer_pkg::addr_mod_low)) begin
      mod_hold_r <= writedata[7:0];
      if (mod_half_r) begin
        mod_r      <= {mod_hold_r, writedata[7:0]};
        mod_half_r <= 1'b0;
      end else begin
        mod_half_r <= 1'b1;
      end
    end
  end

  // coherent counter read latch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      latch_r      <= timer_pkg::count_reset;
      latch_high_r <= 1'b0;
      latch_low_r  <= 1'b0;
    end else if (wr_cnt || wr_sc) begin
      latch_high_r <= 1'b0;
      latch_low_r  <= 1'b0;
    end else if (rd_go && hit(address, timer_pkg::addr_count_high)) begin
      if (latch_low_r) begin
        latch_low_r <= 1'b0;
      end else if (!latch_high_r) begin
        latch_r      <= count_r;
        latch_high_r <= 1'b1;
      end
    end else if (rd_go && hit(address, timer_pkg::addr_count_low)) begin
      if (latch_high_r) begin
        latch_high_r <= 1'b0;
      end else if (!latch_low_r) begin
        latch_r     <= count_r;
        latch_low_r <= 1'b1;
      end
    end
  end

  // status/control; flag set wins over clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sc_r    <= timer_pkg::status_reset;
      armed_r <= 1'b0;
    end else begin
      if (rd_go && hit(address, timer_pkg::addr_status_control)) begin
        armed_r <= sc_r[timer_pkg::flag_bit];
      end
      if (wr_sc) begin
        sc_r[6:0] <= writedata[6:0];
        armed_r   <= 1'b0;
        if (armed_r && !writedata[timer_pkg::flag_bit]) begin
          sc_r[timer_pkg::flag_bit] <= 1'b0;
        end
      end
      if (overflow && !mod_half_r) begin
        sc_r[timer_pkg::flag_bit] <= 1'b1;
        armed_r                   <= 1'b0;
      end
    end
  end

  // pullup control for timer inputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pullup_r <= timer_pkg::pin_reset;
    end else if (wr_go && lane0 && hit(address, timer_pkg::addr_pin_control)) begin
      pullup_r <= writedata[3:0];
    end
  end

  // read data, registered
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readdata_r <= 32'h00000000;
    end else if (rd_go) begin
      case (address)
        timer_pkg::addr_status_control: readdata_r <= {24'h000000, sc_r};
        timer_pkg::addr_count_high:
          readdata_r <= {24'h000000, (latch_high_r | latch_low_r) ? latch_r[15:8] : count_r[15:8]};
        timer_pkg::addr_count_low:
          readdata_r <= {24'h000000, (latch_high_r | latch_low_r) ? latch_r[7:0] : count_r[7:0]};
        timer_pkg::addr_mod_high:       readdata_r <= {24'h000000, mod_r[15:8]};
        timer_pkg::addr_mod_low:        readdata_r <= {24'h000000, mod_r[7:0]};
        timer_pkg::addr_pin_control:    readdata_r <= {28'h0000000, pullup_r};
        default:                        readdata_r <= 32'h00000000;
      endcase
    end
  end

  assign readdata = readdata_r;

  assign overflow_irq = sc_r[timer_pkg::flag_bit] & sc_r[timer_pkg::irq_en_bit];

  // channels need the pin and the timer runs: port controls are overridden
  assign pin_owned_by_timer = (sc_r[timer_pkg::src_msb:timer_pkg::src_lsb] != 2'b00)
                              ? channel_needs_pin : 4'h0;
  assign pullup_enable = pullup_r;

  assign core_view.counter_value      = count_r;
  assign core_view.center_mode_select = sc_r[timer_pkg::center_bit];
  assign core_view.counting_down      = down_r;
endmodule
`default_nettype wire

// ---- timer_counter_sva.sv ----
/*
  timer_counter_sva: port assertions for the shared counter core.
  assumes: bound to timer_counter_core; register bits shadowed on a write's first cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_counter_sva (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  reset,
  // avalon-mm slave
  input wire logic [3:0]            address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [3:0]            byteenable,
  input wire logic [31:0]           writedata,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  // sources, channels and pins
  input wire logic                  fixed_system_clock,
  input wire logic                  ext_timer_clock_pin,
  input wire logic [3:0]            channel_needs_pin,
  input wire timer_pkg::core_view_s core_view,
  input wire logic [3:0]            pin_owned_by_timer,
  input wire logic [3:0]            pullup_enable,
  input wire logic                  overflow_irq
);
  logic [7:0]  sc_r;
  logic        pend_r;
  logic [2:0]  quiet_r;
  logic [15:0] cv;
  logic        wr_ok;
  logic        fast;
  assign cv = core_view.counter_value;
  // the core applies a write on its first cycle, while waitrequest is still high
  assign wr_ok = write && waitrequest && byteenable[0];
  // bus clock, divide by one, no write for seven cycles
  assign fast = quiet_r == 3'h7 && sc_r[4:3] == 2'b01 && sc_r[2:0] == 3'h0;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) sc_r <= 8'h00;
    else if (wr_ok && address == timer_pkg::addr_status_control) sc_r <= writedata[7:0];
  end
  // high when one modulo byte is written and its partner not yet
  always_ff @(posedge clock or posedge reset) begin
    if (reset) pend_r <= 1'b0;
    else if (wr_ok && (address == timer_pkg::addr_mod_high || address == timer_pkg::addr_mod_low))
      pend_r <= !pend_r;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) quiet_r <= 3'h0;
    else if (write) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_reset_values: assert property (
    $fell(reset) |-> core_view == '0 && pin_owned_by_timer == 4'h0 && pullup_enable == 4'h0
      && !overflow_irq) else $error("outputs not cleared by reset");
  a_pin_owner: assert property (
    pin_owned_by_timer == (sc_r[4:3] != 2'b00 ? channel_needs_pin : 4'h0))
    else $error("pin ownership wrong");
  a_center_view: assert property (
    quiet_r == 3'h7 |-> core_view.center_mode_select == sc_r[5]) else $error("center select");
  a_irq_gate: assert property (
    quiet_r >= 3'h2 && !sc_r[6] |-> !overflow_irq) else $error("irq while disabled");
  a_off_hold: assert property (
    quiet_r == 3'h7 && sc_r[4:3] == 2'b00 |=> $stable(cv)) else $error("counts while off");
  a_count_step: assert property (
    fast && !sc_r[5] && !write |=> cv == $past(cv) + 16'h1 || cv == 16'h0)
    else $error("up count step wrong");
  a_up_wrap: assert property (
    fast && !sc_r[5] && sc_r[6] && !pend_r && !write && cv == 16'h0 && $past(cv) != 16'h0
      |-> ##[0:1] overflow_irq) else $error("no flag at wrap");
  a_center_wrap: assert property (
    fast && sc_r[5] && sc_r[6] && !pend_r && cv < $past(cv) && $past(cv, 2) < $past(cv)
      |-> ##[0:1] overflow_irq) else $error("no flag at turn");
  a_count_clear: assert property (
    write && waitrequest && byteenable[0] && (address == timer_pkg::addr_count_high
      || address == timer_pkg::addr_count_low) |=> cv == 16'h0) else $error("no clear");
  c_up_wrap: cover property (fast && cv == 16'h0 && $past(cv) != 16'h0);
  c_down: cover property (core_view.counting_down);
  c_irq: cover property ($rose(overflow_irq));
endmodule
`default_nettype wire

// ---- timer_clock_sources.sv ----
/*
  timer_clock_sources: slow fixed system clock and external pin clock.
  assumes: both toggle from the bus clock, far below the sampling limit.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_clock_sources #(
  parameter int fixed_half = 4,
  parameter int ext_half   = 3
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // slow count sources
  output logic      fixed_system_clock,
  output logic      ext_timer_clock_pin
);
  int fixed_cnt;
  int ext_cnt;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fixed_cnt <= 0;
      fixed_system_clock <= 1'b0;
    end else if (fixed_cnt == fixed_half - 1) begin
      fixed_cnt <= 0;
      fixed_system_clock <= !fixed_system_clock;
    end else fixed_cnt <= fixed_cnt + 1;
  end
  // period of six bus cycles keeps the pin clock under a quarter of the bus rate
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_cnt <= 0;
      ext_timer_clock_pin <= 1'b0;
    end else if (ext_cnt == ext_half - 1) begin
      ext_cnt <= 0;
      ext_timer_clock_pin <= !ext_timer_clock_pin;
    end else ext_cnt <= ext_cnt + 1;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
/*
  testbench: register rows, count sources, flag clearing and reset of the counter core.
  assumes: timer_clock_sources drives the slow count inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int fixed_half = 4;
  localparam int ext_half   = 3;
  logic                  clock, reset, read, write, waitrequest, overflow_irq;
  logic                  fixed_system_clock, ext_timer_clock_pin;
  logic [3:0]            address, byteenable, channel_needs_pin;
  logic [3:0]            pin_owned_by_timer, pullup_enable;
  logic [31:0]           writedata, readdata;
  timer_pkg::core_view_s core_view;
  logic [15:0]           snap, top;
  logic [7:0]            q, lo;
  logic [23:0]           rows [8];
  int                    gap, miscompares, compares;
  timer_counter_core u_dut (.clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .fixed_system_clock(fixed_system_clock),
    .ext_timer_clock_pin(ext_timer_clock_pin), .channel_needs_pin(channel_needs_pin),
    .core_view(core_view), .pin_owned_by_timer(pin_owned_by_timer),
    .pullup_enable(pullup_enable), .overflow_irq(overflow_irq));
  timer_clock_sources #(.fixed_half(fixed_half), .ext_half(ext_half)) u_src (.clock(clock),
    .reset(reset), .fixed_system_clock(fixed_system_clock),
    .ext_timer_clock_pin(ext_timer_clock_pin));
  always #5 clock = !clock;
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      stop_test();
    end
  endtask
  // request held until waitrequest is seen low, released at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, d};
    @(posedge clock);
    snap = core_view.counter_value;
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    limit(n, 20);
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, q);
    check({8'h00, q}, {8'h00, e});
  endtask
  task automatic wait_cv(input logic [15:0] v);
    int n;
    n = 0;
    while (core_view.counter_value !== v && n < 700) begin
      @(negedge clock);
      n++;
    end
    limit(n, 700);
  endtask
  task automatic step_gap;
    logic [15:0] v;
    gap = 0;
    wait_cv(core_view.counter_value + 16'h1);
    v = core_view.counter_value;
    while (core_view.counter_value === v && gap < 400) begin
      @(negedge clock);
      gap++;
    end
    limit(gap, 400);
  endtask
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {read, write, address, writedata} = '0;
    byteenable = 4'h1;
    channel_needs_pin = 4'ha;
    rows = '{24'h7aa000, 24'h755100, 24'h755200, 24'h312400, 24'h434312, 24'h53f50f,
             24'h0e4064, 24'h000700};
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][23:20], rows[i][19:12]);
      rd(rows[i][11:8], rows[i][7:0]);
    end
    check({8'h00, pullup_enable, pin_owned_by_timer}, 16'h00f0);
    $display("register rows done");
    for (int i = 0; i < 10; i++) begin
      wr(4'h0, i < 8 ? {5'h01, i[2:0]} : (i == 8 ? 8'h10 : 8'h18));
      step_gap();
      check(gap[15:0], i < 8 ? 16'h1 << i : 16'(i == 8 ? 2 * fixed_half : 2 * ext_half));
    end
    check({12'h0, pin_owned_by_timer}, 16'h000a);
    $display("count sources done");
    wr(4'h0, 8'h08);
    bus(1'b0, 4'h2, 8'h00, lo);
    top = snap;
    repeat (40) @(posedge clock);
    rd(4'h1, top[15:8]);
    check({8'h00, lo}, {8'h00, top[7:0]});
    $display("coherent read done");
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h4f);
    wait_cv(16'h0001);
    wait_cv(16'h0000);
    @(negedge clock);
    check({15'h0, overflow_irq}, 16'h0001);
    wr(4'h0, 8'h0f);
    check({15'h0, overflow_irq}, 16'h0000);
    rd(4'h0, 8'h8f);
    wr(4'h0, 8'hcf);
    rd(4'h0, 8'hcf);
    wr(4'h0, 8'h4f);
    rd(4'h0, 8'h4f);
    wait_cv(16'h0001);
    wait_cv(16'h0000);
    rd(4'h0, 8'hcf);
    wait_cv(16'h0001);
    wait_cv(16'h0000);
    wr(4'h0, 8'h4f);
    rd(4'h0, 8'hcf);
    wr(4'h0, 8'h4f);
    wr(4'h3, 8'h00);
    wait_cv(16'h0001);
    wait_cv(16'h0000);
    rd(4'h0, 8'h4f);
    wr(4'h4, 8'h01);
    wait_cv(16'h0001);
    wait_cv(16'h0000);
    rd(4'h0, 8'hcf);
    $display("overflow flag done");
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h08);
    wait_cv(16'h0100);
    wr(4'h2, 8'hff);
    rd(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h05);
    rd(4'h0, 8'h88);
    wr(4'h0, 8'h48);
    repeat (30) @(posedge clock);
    wr(4'h0, 8'h68);
    top = 16'h0;
    gap = 0;
    repeat (40) begin
      @(negedge clock);
      if (core_view.counter_value > top) top = core_view.counter_value;
      if (core_view.counting_down) gap = 1;
    end
    check(top, 16'h0005);
    check({core_view.center_mode_select, gap[14:0]}, 16'h8001);
    $display("modes done");
    @(posedge clock);
    reset <= 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (10) @(posedge clock);
    check(core_view.counter_value, 16'h0000);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h00);
    check({8'h00, pullup_enable, pin_owned_by_timer}, 16'h0000);
    $display("second reset done");
    stop_test();
  end
endmodule
bind timer_counter_core timer_counter_sva u_sva (.clock(clock), .reset(reset),
  .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .fixed_system_clock(fixed_system_clock), .ext_timer_clock_pin(ext_timer_clock_pin),
  .channel_needs_pin(channel_needs_pin), .core_view(core_view),
  .pin_owned_by_timer(pin_owned_by_timer), .pullup_enable(pullup_enable),
  .overflow_irq(overflow_irq));
`default_nettype wire
